// ===== src/spi_port_regs.svh
// Purpose: register offsets, bit positions and reset values of the SPI port
// Assumes: 32-bit classic Wishbone, one aligned word per register
// Notes: register data sits in the low byte; upper bits read as zero
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define IFLAG_OFS 8'h08
`define TXB_OFS 8'h0c
`define RXB_OFS 8'h10

`define CTRL_GOMODE 3
`define CTRL_GO 4
`define CTRL_CKE 5
`define CTRL_EN 6

`define STAT_RXFULL 0
`define STAT_RXST 1
`define STAT_TXEMPTY 5
`define STAT_TXST 6

`define IFLAG_RXIRQ 2
`define IFLAG_TXIRQ 7

`define BYTE_RST 8'h00
`define LAST_BIT 4'h7

`endif

// ===== src/spi_port_pkg.sv
// Purpose: types shared by the SPI port
// Assumes: nothing beyond the register header
// Notes: the whole module state is one packed struct
package spi_port_pkg;

  typedef enum logic [2:0] {
    MODE_DIV2 = 3'h0,
    MODE_DIV4 = 3'h1,
    MODE_DIV8 = 3'h2,
    MODE_DIV16 = 3'h3,
    MODE_DIV32 = 3'h4,
    MODE_SLV_GATED = 3'h5,
    MODE_SLV_FREE = 3'h6,
    MODE_TMR = 3'h7
  } mode_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_SHIFT = 3'b010,
    PH_TAIL = 3'b100
  } phase_type;

  typedef struct packed {
    logic en;
    logic cke;
    logic go;
    logic go_mode;
    mode_type mode;
  } ctrl_type;

  typedef struct packed {
    logic tx_empty;
    logic tx_st;
    logic tx_irq;
    logic rx_full;
    logic rx_st;
    logic rx_irq;
  } flags_type;

  typedef struct packed {
    logic sck1;
    logic sck2;
    logic sck3;
    logic sdi1;
    logic sdi2;
    logic ssb1;
    logic ssb2;
  } sync_type;

  typedef struct packed {
    ctrl_type ctrl;
    flags_type fl;
    sync_type sy;
    phase_type phase;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic [7:0] sr;
    logic din;
    logic [3:0] cnt;
    logic pend;
    logic [3:0] div;
    logic t1_prev;
    logic sck;
    logic sck_oe_n;
    logic sdo;
    logic sdo_oe_n;
    logic ack;
    logic [31:0] rdata;
  } state_type;

endpackage : spi_port_pkg

// ===== src/spi_port.sv
// Purpose: eight-bit full-duplex SPI port, master or slave, Wishbone regs
// Assumes: pins sck, sdi and select_bar arrive asynchronous to clk_i
// Notes: two-way sck pin split into input, output and low-active enable
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "spi_port_regs.svh"

// Functional notes
// R01: modes 000-100 master, sck fosc/2 to fosc/32
// R02: mode 101 slave, pin clock, select gating
// R03: mode 110 slave, select pin ignored
// R04: mode 111 master, sck timer-one output halved
// R05: edge select 1: drive falling, sample rising
// R06: edge select 0: drive rising, sample falling
// R07: master go bit starts transfer, loads, flags
// R08: go bit held while shifting, cleared after
// R09: eight bits in: receive buffer loaded, flags
// R10: start and done flags cleared only by software
// R11: tx empty cleared by software or buffer write
// R12: rx full cleared by software or buffer read
// R13: master write-start mode: buffer write starts transfer
// R14: write-start mode stops sck without next byte
// R15: software writes next byte before current ends
// R16: slave go mode: go loads, sck paces shifting
// R17: slave software rearms go before next sck
// R18: gated slave works only while select low
// R19: select high releases sdo immediately, mid-byte
// R20: select high or disable clears bit counter
// R21: software enables and sets mode before starting
// R22: software reads receive buffer before next byte
// R23: msb first, eight bits each way together
// R24: go bit 4, go mode bit 3 of control
// R25: master sck runs only during a byte
module spi_port
  import spi_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer1_out_i,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  input wire logic select_bar_pin_n_i
);

  state_type s;
  state_type next_s;

  always_comb
  begin
    logic master;
    logic mod_rst;
    logic tick;
    logic edge_seen;
    logic lvl;
    logic samp;
    logic drv;
    logic req;
    logic wr;
    logic rd;
    logic wr_txb;
    logic start_go;
    logic load;
    logic [3:0] half_m1;
    next_s = s;
    master = 1'b0;
    mod_rst = 1'b0;
    tick = 1'b0;
    edge_seen = 1'b0;
    lvl = 1'b0;
    samp = 1'b0;
    drv = 1'b0;
    req = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wr_txb = 1'b0;
    start_go = 1'b0;
    load = 1'b0;
    half_m1 = 4'h0;

    // pin synchronisers; first stage feeds only the second
    next_s.sy.sck1 = sck_i;
    next_s.sy.sck2 = s.sy.sck1;
    next_s.sy.sck3 = s.sy.sck2;
    next_s.sy.sdi1 = sdi_i;
    next_s.sy.sdi2 = s.sy.sdi1;
    next_s.sy.ssb1 = select_bar_pin_n_i;
    next_s.sy.ssb2 = s.sy.ssb1;
    next_s.t1_prev = timer1_out_i;

    // register bus: one wait state, ack drops after one cycle
    req = wb_cyc_i & wb_stb_i & ~s.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    rd = req & ~wb_we_i;
    next_s.ack = req;
    wr_txb = wr && (wb_adr_i == `TXB_OFS);

    if (wr && (wb_adr_i == `CTRL_OFS))
    begin
      next_s.ctrl.mode = mode_type'(wb_dat_i[2:0]);
      next_s.ctrl.go_mode = wb_dat_i[`CTRL_GOMODE]; // [R24]
      next_s.ctrl.go = wb_dat_i[`CTRL_GO]; // [R24]
      next_s.ctrl.cke = wb_dat_i[`CTRL_CKE];
      next_s.ctrl.en = wb_dat_i[`CTRL_EN];
      start_go = wb_dat_i[`CTRL_GO] & ~wb_dat_i[`CTRL_GOMODE];
    end
    if (wr_txb)
    begin
      next_s.txb = wb_dat_i[7:0];
      next_s.fl.tx_empty = 1'b0; // [R11]
    end
    // flags clear on a written zero; a written one is ignored
    if (wr && (wb_adr_i == `STAT_OFS))
    begin
      if (!wb_dat_i[`STAT_RXFULL])
        next_s.fl.rx_full = 1'b0; // [R12]
      if (!wb_dat_i[`STAT_RXST])
        next_s.fl.rx_st = 1'b0; // [R10]
      if (!wb_dat_i[`STAT_TXEMPTY])
        next_s.fl.tx_empty = 1'b0; // [R11]
      if (!wb_dat_i[`STAT_TXST])
        next_s.fl.tx_st = 1'b0; // [R10]
    end
    if (wr && (wb_adr_i == `IFLAG_OFS))
    begin
      if (!wb_dat_i[`IFLAG_RXIRQ])
        next_s.fl.rx_irq = 1'b0; // [R10]
      if (!wb_dat_i[`IFLAG_TXIRQ])
        next_s.fl.tx_irq = 1'b0; // [R10]
    end
    if (rd && (wb_adr_i == `RXB_OFS))
      next_s.fl.rx_full = 1'b0; // [R12]

    master = (next_s.ctrl.mode != MODE_SLV_GATED) &&
             (next_s.ctrl.mode != MODE_SLV_FREE); // [R01] [R02] [R03] [R04]
    mod_rst = ~next_s.ctrl.en |
              ((next_s.ctrl.mode == MODE_SLV_GATED) & s.sy.ssb2); // [R18] [R20]

    // master sck source: divided clock or timer-one edges
    half_m1 = 4'((5'h1 << s.ctrl.mode[2:0]) - 5'h1); // [R01]
    if (master && (s.phase != PH_IDLE))
    begin
      if (s.ctrl.mode == MODE_TMR)
        tick = timer1_out_i & ~s.t1_prev; // [R04]
      else if (s.div == 4'h0)
      begin
        tick = 1'b1;
        next_s.div = half_m1; // [R01]
      end
      else
        next_s.div = s.div - 4'h1;
    end

    if (master)
    begin
      edge_seen = tick;
      lvl = ~s.sck;
    end
    else
    begin
      edge_seen = s.sy.sck2 ^ s.sy.sck3;
      lvl = s.sy.sck2;
    end
    // sampling edge is the one that lands on the edge-select level
    samp = edge_seen & (lvl == s.ctrl.cke); // [R05] [R06]
    drv = edge_seen & (lvl != s.ctrl.cke); // [R05] [R06]
    if (tick)
      next_s.sck = ~s.sck; // [R25]

    unique case (s.phase)
      PH_IDLE:
      begin
        if (start_go && next_s.ctrl.en)
          load = 1'b1; // [R07] [R16]
        else if (wr_txb && master && next_s.ctrl.go_mode)
          load = 1'b1; // [R13]
        else if (!master && s.ctrl.go_mode && samp)
        begin
          // a slave in write-start mode, gated or free, loads on the first sampling edge
          load = 1'b1;
          next_s.din = s.sy.sdi2;
          next_s.cnt = 4'h1;
        end
      end
      PH_SHIFT:
      begin
        if (wr_txb && s.ctrl.go_mode)
          next_s.pend = 1'b1; // [R15]
        if (samp)
        begin
          next_s.din = s.sy.sdi2;
          if (s.cnt == `LAST_BIT)
          begin
            next_s.rxb = {s.sr[6:0], s.sy.sdi2}; // [R09] [R22] [R23]
            next_s.fl.rx_full = 1'b1; // [R09]
            next_s.fl.rx_st = 1'b1; // [R09]
            next_s.fl.rx_irq = 1'b1; // [R09]
            next_s.ctrl.go = 1'b0; // [R08]
            next_s.cnt = 4'h0;
            if (master)
              next_s.phase = PH_TAIL;
            else
              next_s.phase = PH_IDLE;
          end
          else
            next_s.cnt = s.cnt + 4'h1;
        end
        if (drv)
          next_s.sr = {s.sr[6:0], s.din}; // [R23]
      end
      PH_TAIL:
      begin
        if (wr_txb && s.ctrl.go_mode)
          next_s.pend = 1'b1; // [R15]
        // last edge returns sck to idle, then stop or chain
        if (drv)
        begin
          if (next_s.pend && s.ctrl.go_mode)
            load = 1'b1; // [R13]
          else
            next_s.phase = PH_IDLE; // [R14] [R25]
        end
      end
      default:
        next_s.phase = PH_IDLE;
    endcase

    if (load && !mod_rst)
    begin
      next_s.sr = next_s.txb; // [R07] [R13] [R16]
      next_s.phase = PH_SHIFT;
      next_s.pend = 1'b0;
      next_s.div = half_m1;
      if (s.phase != PH_IDLE || !(!master && s.ctrl.go_mode))
        next_s.cnt = 4'h0;
      next_s.fl.tx_empty = 1'b1; // [R07] [R11]
      next_s.fl.tx_st = 1'b1; // [R07] [R10]
      next_s.fl.tx_irq = 1'b1; // [R07] [R10]
    end

    if (mod_rst)
    begin
      next_s.phase = PH_IDLE;
      next_s.cnt = 4'h0; // [R20]
      next_s.pend = 1'b0;
    end
    // sck idles at the level opposite the sampling edge
    if (next_s.phase == PH_IDLE)
      next_s.sck = ~next_s.ctrl.cke; // [R25]

    next_s.sdo = (next_s.phase != PH_IDLE) ? next_s.sr[7] : next_s.txb[7];
    next_s.sdo_oe_n = mod_rst; // [R18] [R19]
    next_s.sck_oe_n = ~(next_s.ctrl.en & master);

    next_s.rdata = 32'h0;
    if (rd)
    begin
      unique case (wb_adr_i)
        `CTRL_OFS:
        begin
          next_s.rdata[2:0] = s.ctrl.mode;
          next_s.rdata[`CTRL_GOMODE] = s.ctrl.go_mode;
          next_s.rdata[`CTRL_GO] = s.ctrl.go; // [R08]
          next_s.rdata[`CTRL_CKE] = s.ctrl.cke;
          next_s.rdata[`CTRL_EN] = s.ctrl.en;
        end
        `STAT_OFS:
        begin
          next_s.rdata[`STAT_RXFULL] = s.fl.rx_full;
          next_s.rdata[`STAT_RXST] = s.fl.rx_st;
          next_s.rdata[`STAT_TXEMPTY] = s.fl.tx_empty;
          next_s.rdata[`STAT_TXST] = s.fl.tx_st;
        end
        `IFLAG_OFS:
        begin
          next_s.rdata[`IFLAG_RXIRQ] = s.fl.rx_irq;
          next_s.rdata[`IFLAG_TXIRQ] = s.fl.tx_irq;
        end
        `TXB_OFS:
          next_s.rdata[7:0] = s.txb;
        `RXB_OFS:
          next_s.rdata[7:0] = s.rxb;
        default:
          next_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.phase <= PH_IDLE;
      s.txb <= `BYTE_RST;
      s.rxb <= `BYTE_RST;
      s.sck <= 1'b1;
      s.sck_oe_n <= 1'b1;
      s.sdo_oe_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign sck_o = s.sck;
  assign sck_oe_n_o = s.sck_oe_n;
  assign sdo_o = s.sdo;
  assign sdo_oe_n_o = s.sdo_oe_n;

endmodule : spi_port

// ===== testbench/spi_port_assertions.sv
// Purpose: bus and pin checks of spi_port
// Assumes: a write takes effect at its request edge
// Notes: mode and tx byte are snooped off the bus
`timescale 1ns/1ps
module spi_port_assertions
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer1_out_i,
  input wire logic sck_i,
  input wire logic sck_o,
  input wire logic sck_oe_n_o,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  input wire logic select_bar_pin_n_i
);
  logic [6:0] ctl;
  logic [7:0] txs;
  logic wr;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl <= 7'h00;
      txs <= 8'h00;
    end
    else if (wr && wb_adr_i == 8'h00)
      ctl <= wb_dat_i[6:0];
    else if (wr && wb_adr_i == 8'h0c)
      txs <= wb_dat_i[7:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i > 8'h10 |-> wb_dat_o == 32'h0) else $error("unmapped read");
  chk_txb_readback: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == 8'h0c |-> wb_dat_o == {24'h0, txs}) else $error("txb read");
  chk_master_drive: assert property ((ctl[6] && (ctl[2:0] < 3'h5 ||
    ctl[2:0] == 3'h7))[*2] |-> !sck_oe_n_o && !sdo_oe_n_o)
    else $error("master not driving");
  chk_off_float: assert property ((!ctl[6])[*2] |-> sck_oe_n_o &&
    sdo_oe_n_o) else $error("disabled port drives");
  chk_select_release: assert property ((ctl[6] && ctl[2:0] == 3'h5 &&
    select_bar_pin_n_i)[*5] |-> sdo_oe_n_o)
    else $error("sdo not released");
  chk_sck_rate: assert property (ctl[2:0] == 3'h2 && !sck_oe_n_o &&
    !$past(sck_oe_n_o) && $changed(sck_o) |=> $stable(sck_o)[*3])
    else $error("sck half period");
  cover property (wb_ack_o && wb_adr_i > 8'h10);
  cover property (!sck_oe_n_o && $changed(sck_o));
  cover property (ctl[6] && ctl[2:0] == 3'h5 && sdo_oe_n_o);
endmodule : spi_port_assertions
bind spi_port spi_port_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer1_out_i(timer1_out_i),
  .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .sdi_i(sdi_i),
  .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
  .select_bar_pin_n_i(select_bar_pin_n_i));

// ===== testbench/spi_far_end.sv
// Purpose: far-side spi device
// Assumes: first edge of a byte is the sampling edge
// Notes: sdi keeps changing after a byte, never holds a stale bit
`timescale 1ns/1ps
module spi_far_end
(
  input wire logic sck_i,
  input wire logic sdo_i,
  input wire logic cke_i,
  input wire logic load_i,
  input wire logic [7:0] tx_i,
  output logic sdi_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh = 8'h00;
  initial rx_o = 8'h00;
  assign sdi_o = sh[7];
  always @(posedge sck_i or negedge sck_i or posedge load_i)
  begin
    if (load_i)
      sh <= tx_i;
    else if (sck_i == cke_i)
      rx_o <= {rx_o[6:0], sdo_i};
    else
      sh <= {sh[6:0], ~sh[0]};
  end
endmodule : spi_far_end

// ===== testbench/tb_top.sv
// Purpose: self-checking bench of spi_port
// Assumes: far device reloaded after each enable
// Notes: modes 0 and 1 check only the outgoing byte; sdi sync lags there
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic ext = 1'b0;
  logic sel_n = 1'b1;
  logic ld = 1'b0;
  logic cke, ack, sck_o, sck_oe_n, sdo_o, sdo_oe_n, sdi, sck_w, sdo_w, sc;
  logic [2:0] tdiv = 3'h0;
  logic [7:0] adr = 8'h00;
  logic [7:0] ftx, frx, r, b, c;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic [2:0] ml [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  byte q [$];
  int num_errors = 0;
  int cmp_count = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) tdiv <= tdiv + 3'($urandom % 2);
  assign sck_w = sck_oe_n ? ext : sck_o;
  assign sdo_w = sdo_oe_n ? 1'b1 : sdo_o;
  spi_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer1_out_i(tdiv[2]), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_n_o(sck_oe_n), .sdi_i(sdi), .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n), .select_bar_pin_n_i(sel_n));
  spi_far_end far (.sck_i(sck_w), .sdo_i(sdo_w), .cke_i(cke), .load_i(ld),
    .tx_i(ftx), .sdi_o(sdi), .rx_o(frx));
  task give_verdict;
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic wb(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    r = rdat[7:0];
    cyc <= 1'b0;
    if (ack !== 1'b1)
      chk("ack", 8'h01, 8'h00);
    if (ack !== 1'b1)
      give_verdict;
  endtask : wb
  task automatic rc(string n, logic [7:0] a, logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(n, e, r);
  endtask : rc
  task automatic wait_rx;
    int n;
    n = 0;
    r = 8'h00;
    while (r[0] !== 1'b1 && n < 500)
    begin
      wb(1'b0, 8'h04, 8'h00);
      n++;
    end
    if (r[0] !== 1'b1)
      chk("rx done", 8'h01, 8'h00);
    if (r[0] !== 1'b1)
      give_verdict;
  endtask : wait_rx
  task automatic fload(logic [7:0] v);
    ftx = v;
    q.push_back(v);
    ld = 1'b1;
    #1 ld = 1'b0;
  endtask : fload
  task automatic pulses(int k);
    repeat (k)
    begin
      repeat (6) @(posedge clk_i);
      ext <= 1'b1;
      repeat (6) @(posedge clk_i);
      ext <= 1'b0;
    end
  endtask : pulses
  initial
  begin
    void'($urandom(32'h5d4b));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 6; a++)
      rc("reset value", 8'(a * 4), 8'h00);
    foreach (ml[i])
    begin
      cke = 1'($urandom);
      b = 8'($urandom);
      c = {2'b01, cke, 2'b00, ml[i]};
      wb(1'b1, 8'h00, c);
      fload(8'($urandom));
      wb(1'b1, 8'h0c, b);
      rc("txb", 8'h0c, b);
      rc("stat", 8'h04, 8'h00);
      wb(1'b1, 8'h00, c | 8'h10);
      rc("ctrl busy", 8'h00, c | 8'h10);
      wait_rx;
      rc("ctrl done", 8'h00, c);
      rc("stat", 8'h04, 8'h63);
      // at the two fastest rates the synced sdi lags, rxb is not predictable
      if (ml[i] < 3'h2)
      begin
        wb(1'b0, 8'h10, 8'h00);
        void'(q.pop_front());
      end
      else
        rc("rxb", 8'h10, q.pop_front());
      chk("far rx", b, frx);
      rc("stat", 8'h04, 8'h62);
      rc("iflag", 8'h08, 8'h84);
      wb(1'b1, 8'h08, 8'h00);
      wb(1'b1, 8'h04, 8'h20);
      rc("iflag", 8'h08, 8'h00);
      wb(1'b1, 8'h00, 8'h00);
    end
    cke = 1'b0;
    wb(1'b1, 8'h00, 8'h4a);
    fload(8'($urandom));
    wb(1'b1, 8'h0c, 8'h3c);
    wb(1'b1, 8'h0c, 8'hc5);
    wait_rx;
    rc("rxb chain", 8'h10, q.pop_front());
    wait_rx;
    chk("far chain", 8'hc5, frx);
    repeat (8) @(posedge clk_i);
    sc = sck_w;
    repeat (40)
    begin
      @(posedge clk_i);
      chk("sck idle", {7'h0, sc}, {7'h0, sck_w});
    end
    wb(1'b1, 8'h00, 8'h00);
    cke = 1'b1;
    wb(1'b1, 8'h00, 8'h66);
    fload(8'($urandom));
    wb(1'b1, 8'h0c, 8'h96);
    wb(1'b1, 8'h00, 8'h76);
    pulses(8);
    wait_rx;
    rc("rxb slave", 8'h10, q.pop_front());
    chk("far slave", 8'h96, frx);
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h00, 8'h65);
    sel_n <= 1'b0;
    wb(1'b1, 8'h0c, 8'h5a);
    wb(1'b1, 8'h00, 8'h75);
    pulses(3);
    sel_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("sdo float", 8'h01, {7'h0, sdo_oe_n});
    sel_n <= 1'b0;
    // select passes two sync stages before go may be written
    repeat (3) @(posedge clk_i);
    fload(8'($urandom));
    wb(1'b1, 8'h00, 8'h75);
    pulses(8);
    wait_rx;
    rc("rxb gated", 8'h10, q.pop_front());
    chk("far gated", 8'h5a, frx);
    sel_n <= 1'b1;
    fload(8'($urandom));
    wb(1'b1, 8'h00, 8'h6e);
    wb(1'b1, 8'h0c, 8'ha7);
    pulses(8);
    wait_rx;
    rc("rxb free", 8'h10, q.pop_front());
    chk("far free", 8'ha7, frx);
    give_verdict;
  end
endmodule : tb_top
